/* File: verilog/mlsd_regs.vh */
/*
  register offsets, field positions, reset values and timing counts
  for the load measurement and stall detect block; definitions only
*/
`ifndef MLSD_REGS_VH
`define MLSD_REGS_VH

`define MLSD_CTRL_ADDR     12'h000
`define MLSD_VALUE_ADDR    12'h004
`define MLSD_STATUS_ADDR   12'h008
`define MLSD_INT_EN_ADDR   12'h00C
`define MLSD_INT_CLR_ADDR  12'h010

`define MLSD_CTRL_OFS_LSB  0
`define MLSD_CTRL_OFS_MSB  6
`define MLSD_CTRL_FILT_BIT 8
`define MLSD_OFS_RESET     7'h00
`define MLSD_FILT_RESET    1'b0

`define MLSD_EV_UPDATE     0
`define MLSD_EV_STALL      1
`define MLSD_EV_W          2

`define MLSD_VALUE_RESET   10'h3FF
`define MLSD_VALUE_MAX     12'h3FF
`define MLSD_OFS_SCALE     4
`define MLSD_FILT_STEPS    2'h3

`endif

/* File: verilog/mlsd_avg.v */
/*
  four-sample averager for offset-corrected load samples.
  assumes sample_valid is a one-cycle pulse per full step.
*/
`timescale 1ns/1ps
module mlsd_avg
(
  input  wire        clk,
  input  wire        rst,
  input  wire        sample_valid,
  input  wire [9:0]  sample,
  output reg         avg_valid,
  output reg  [9:0]  avg
);
  reg [11:0] acc;
  reg [1:0]  cnt;
  wire [11:0] sum;

  assign sum = acc + {2'h0, sample};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc       <= 12'h000;
      cnt       <= 2'h0;
      avg_valid <= 1'b0;
      avg       <= 10'h000;
    end
    else
    begin
      avg_valid <= 1'b0;
      if (sample_valid)
      begin
        if (cnt == 2'h3)
        begin
          avg       <= sum[11:2];
          avg_valid <= 1'b1;
          acc       <= 12'h000;
        end
        else
          acc <= sum;
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

/* File: verilog/mlsd_top.v */
/*
  load value and stall detect logic with an apb register slave:
  offset correction, optional four-step averaging, stall output,
  sticky event status with one level interrupt.
  assumes full_step is a pin-level strobe and raw_load comes from the
  measurement front end, stable from a few cycles before full_step
  rises until it falls; steps are spaced at least four clocks apart;
  the apb master holds each request until pready is seen high.
*/
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
// What this block does
// - a 7-bit two's complement offset sets stall level and shifts the reported range.
// - zero offset is neutral, positive lowers sensitivity, negative raises it.
// - with filtering on, four samples are averaged and one value is published per four steps.
// - with filtering off, the value is refreshed at every full step.
// - the load value is a 10-bit unsigned number from 0 to 1023.
// - larger values mean lighter load and 0 is the highest load.
// - the stall output is high while the load value reads 0.
`timescale 1ns/1ps
`include "mlsd_regs.vh"
module mlsd_top
(
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        full_step,
  input  wire [9:0]  raw_load,
  output reg         stall_flag_output,
  output reg         irq
);
  reg  [6:0]  load_threshold_offset;
  reg         load_filter_enable;
  reg  [9:0]  load_value;
  wire [`MLSD_EV_W-1:0] status;
  reg  [`MLSD_EV_W-1:0] int_en;
  reg  [`MLSD_EV_W-1:0] events;
  reg  [1:0]  step_sync;
  wire [9:0]  raw_s2;
  reg         step_prev;
  reg         sample_valid;
  reg  [9:0]  sample;
  reg  [9:0]  next_load_value;
  reg         next_update;
  reg  [31:0] next_prdata;
  reg         next_slverr;
  wire        avg_valid;
  wire [9:0]  avg;
  wire        step_rise;
  wire        wr_access;
  wire        rd_access;
  wire        ctrl_wr;
  wire        int_en_wr;
  wire        clr_access;
  wire        value_zero;
  genvar      gi;

  // offset scaled and sign-extended, added so positive raises the value
  // and more load is needed before the value reaches zero
  function [9:0] apply_offset;
    input [9:0] raw;
    input [6:0] ofs;
    reg signed [31:0] raw_w;
    reg signed [31:0] ofs_w;
    reg signed [31:0] t;
    begin
      raw_w = {22'h000000, raw};
      ofs_w = {{25{ofs[6]}}, ofs};
      t     = raw_w + ofs_w * `MLSD_OFS_SCALE;
      if (t < 0)
        apply_offset = 10'h000;
      else if (t > {20'h00000, `MLSD_VALUE_MAX})
        apply_offset = 10'h3FF;
      else
        apply_offset = t[9:0];
    end
  endfunction

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  assign step_rise = step_sync[1] & ~step_prev;
  assign wr_access = psel & penable & pwrite & ~pready;
  assign rd_access = psel & penable & ~pwrite & ~pready;
  assign ctrl_wr    = wr_access & is_addr(paddr, `MLSD_CTRL_ADDR);
  assign int_en_wr  = wr_access & is_addr(paddr, `MLSD_INT_EN_ADDR);
  assign clr_access = wr_access & is_addr(paddr, `MLSD_INT_CLR_ADDR);
  assign value_zero = (next_load_value == 10'h000);

  // synchronise the step strobe and the sample it qualifies
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step_sync <= 2'h0;
      step_prev <= 1'b0;
    end
    else
    begin
      step_sync <= {step_sync[0], full_step};
      step_prev <= step_sync[1];
    end
  end

  // two flops on every sample bit
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_raw_sync
      reg s1;
      reg s2;
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end
        else
        begin
          s1 <= raw_load[gi];
          s2 <= s1;
        end
      end
      assign raw_s2[gi] = s2;
    end
  endgenerate

  // one offset-corrected sample per full step
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sample_valid <= 1'b0;
      sample       <= 10'h000;
    end
    else
    begin
      sample_valid <= step_rise;
      if (step_rise)
        sample <= apply_offset(raw_s2, load_threshold_offset);
    end
  end

  mlsd_avg u_avg
  (
    .clk          (clk),
    .rst          (rst),
    .sample_valid (sample_valid & load_filter_enable),
    .sample       (sample),
    .avg_valid    (avg_valid),
    .avg          (avg)
  );

  always @*
  begin
    next_update     = 1'b0;
    next_load_value = load_value;
    if (load_filter_enable)
    begin
      if (avg_valid)
      begin
        next_update     = 1'b1;
        next_load_value = avg;
      end
    end
    else if (sample_valid)
    begin
      next_update     = 1'b1;
      next_load_value = sample;
    end
  end

  // published value holds between update points
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_value        <= `MLSD_VALUE_RESET;
      stall_flag_output <= 1'b0;
      events            <= {`MLSD_EV_W{1'b0}};
    end
    else
    begin
      load_value        <= next_load_value;
      stall_flag_output <= value_zero;
      events[`MLSD_EV_UPDATE] <= next_update;
      events[`MLSD_EV_STALL]  <= next_update & value_zero & ~stall_flag_output;
    end
  end

  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (is_addr(paddr, `MLSD_CTRL_ADDR))
    begin
      next_prdata[`MLSD_CTRL_OFS_MSB:`MLSD_CTRL_OFS_LSB] = load_threshold_offset;
      next_prdata[`MLSD_CTRL_FILT_BIT] = load_filter_enable;
    end
    else if (is_addr(paddr, `MLSD_VALUE_ADDR))
      next_prdata[9:0] = load_value;
    else if (is_addr(paddr, `MLSD_STATUS_ADDR))
      next_prdata[`MLSD_EV_W-1:0] = status;
    else if (is_addr(paddr, `MLSD_INT_EN_ADDR))
      next_prdata[`MLSD_EV_W-1:0] = int_en;
    else if (!is_addr(paddr, `MLSD_INT_CLR_ADDR))
      next_slverr = 1'b1;
  end

  // apb slave: one wait state, answer in the second access cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      load_threshold_offset <= `MLSD_OFS_RESET;
      load_filter_enable    <= `MLSD_FILT_RESET;
      int_en                <= {`MLSD_EV_W{1'b0}};
    end
    else
    begin
      pready  <= wr_access | rd_access;
      pslverr <= (wr_access | rd_access) & next_slverr;
      prdata  <= rd_access ? next_prdata : 32'h0000_0000;
      if (ctrl_wr)
      begin
        load_threshold_offset <= pwdata[`MLSD_CTRL_OFS_MSB:`MLSD_CTRL_OFS_LSB];
        load_filter_enable    <= pwdata[`MLSD_CTRL_FILT_BIT];
      end
      if (int_en_wr)
        int_en <= pwdata[`MLSD_EV_W-1:0];
    end
  end

  // sticky status: set wins over write-one-to-clear
  generate
    for (gi = 0; gi < `MLSD_EV_W; gi = gi + 1)
    begin : g_status
      reg bit_q;
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          bit_q <= 1'b0;
        else if (events[gi])
          bit_q <= 1'b1;
        else if (clr_access && pwdata[gi])
          bit_q <= 1'b0;
      end
      assign status[gi] = bit_q;
    end
  endgenerate

  // level interrupt, one cycle behind the status bits
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status & int_en);
  end
endmodule

/* File: dv/mlsd_checker.sv */
/* port assertions for the load value block
   bound to mlsd_top, sees its ports only */
`timescale 1ns/1ps
module mlsd_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        full_step,
  input wire logic        stall_flag_output,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready too long");
  property p_take; psel && penable && !pready |=> pready; endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_src; pready |-> $past(psel && penable); endproperty
  a_src: assert property (p_src) else $error("stray pready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("prdata not idle");
  property p_errd; pslverr |-> prdata == 32'h0; endproperty
  a_errd: assert property (p_errd) else $error("error read not zero");
  property p_stall;
    $changed(stall_flag_output) |-> $past(full_step, 3) || $past(full_step, 4)
      || $past(full_step, 5);
  endproperty
  a_stall: assert property (p_stall) else $error("stall moved off step");
  property p_irq;
    $fell(irq) |-> $past(penable, 1) || $past(penable, 2) || $past(penable, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("irq fell unasked");
endmodule
bind mlsd_top mlsd_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .full_step(full_step),
  .stall_flag_output(stall_flag_output), .irq(irq));

/* File: dv/mlsd_front.sv */
/* front end model: raw sample and full step strobe
   driven right after rising clk edges */
`timescale 1ns/1ps
module mlsd_front
(
  input  wire       clk,
  output reg        full_step,
  output reg  [9:0] raw_load
);
  initial
  begin
    full_step = 1'b0;
    raw_load = 10'h000;
  end
  task step(input [9:0] v);
    begin
      @(posedge clk) raw_load <= v;
      repeat (4) @(posedge clk);
      full_step <= 1'b1;
      repeat (4) @(posedge clk);
      full_step <= 1'b0;
      repeat (6) @(posedge clk);
      // stale sample is not held
      raw_load <= ~v;
    end
  endtask
endmodule

/* File: dv/mlsd_tb.sv */
/* self-checking bench: apb register and load path tests
   mlsd_front stands in for the measurement front end */
`timescale 1ns/1ps
`include "mlsd_regs.vh"
module testbench;
  reg         clk;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        full_step;
  wire [9:0]  raw_load;
  wire        stall_flag_output;
  wire        irq;
  reg  [31:0] rd;
  reg         err;
  integer     error_cnt = 0;
  integer     checks = 0;
  mlsd_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_step(full_step), .raw_load(raw_load), .stall_flag_output(stall_flag_output),
    .irq(irq));
  mlsd_front u_fe (.clk(clk), .full_step(full_step), .raw_load(raw_load));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 20)
        error_cnt = error_cnt + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rv(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task ld(input [6:0] o, input [9:0] r, input [9:0] e);
    begin
      apb(1'b1, `MLSD_CTRL_ADDR, {25'h0, o});
      u_fe.step(r);
      rv(`MLSD_VALUE_ADDR, {22'h0, e});
      chk(stall_flag_output, e == 10'h000);
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rv(`MLSD_CTRL_ADDR, 32'h0);
    rv(`MLSD_VALUE_ADDR, 32'h3FF);
    apb(1'b1, `MLSD_CTRL_ADDR, 32'h100);
    u_fe.step(10'h064);
    u_fe.step(10'h0C8);
    u_fe.step(10'h12C);
    rv(`MLSD_VALUE_ADDR, 32'h3FF);
    u_fe.step(10'h190);
    rv(`MLSD_VALUE_ADDR, 32'h0FA);
    apb(1'b1, `MLSD_INT_EN_ADDR, 32'h3);
    ld(7'h00, 10'h1F4, 10'h1F4);
    ld(7'h05, 10'h1F4, 10'h208);
    ld(7'h00, 10'h014, 10'h014);
    ld(7'h76, 10'h014, 10'h000);
    ld(7'h76, 10'h3FF, 10'h3D7);
    ld(7'h3F, 10'h3FF, 10'h3FF);
    ld(7'h7D, 10'h1F4, 10'h1E8);
    chk(irq, 1'b1);
    rv(`MLSD_STATUS_ADDR, 32'h3);
    apb(1'b1, `MLSD_INT_CLR_ADDR, 32'h3);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, `MLSD_INT_EN_ADDR, 32'h0);
    u_fe.step(10'h1F4);
    chk(irq, 1'b0);
    rv(`MLSD_STATUS_ADDR, 32'h1);
    apb(1'b1, `MLSD_VALUE_ADDR, 32'h0);
    rv(`MLSD_VALUE_ADDR, 32'h1E8);
    apb(1'b0, 12'h014, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    report_and_stop;
  end
endmodule
